// file: rtl/ptc_pkg.sv
// ptc_pkg: shared constants and codes for the privilege transfer checker.
// assumes: one core clock, synchronous active-high reset; every user writes ptc_pkg::name.
package ptc_pkg;
  // fault raised on any refused transfer
  localparam logic [7:0] GP_FAULT_VEC = 8'h0d;
  // nested task bit within the flags word
  localparam int NT_BIT = 14;
  // requested level sits in the low two selector bits
  localparam int RL_MSB = 1;
  localparam int RL_LSB = 0;

  // register port offsets and field positions
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_IF_BIT = 0;
  localparam int CTRL_LVL_LSB = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_TSW_BIT = 2;
  localparam int STAT_CNT_LSB = 8;

  // values after reset
  localparam logic [1:0] CUR_LEVEL_RST = 2'h0;
  localparam logic IF_RST = 1'b0;

  // stack slot sizes in bytes
  localparam logic [31:0] SLOT32_BYTES = 32'h4;
  localparam logic [31:0] SLOT16_BYTES = 32'h2;

  // transfer operations presented by decode
  typedef enum logic [2:0] {
    OP_JUMP = 3'h0,
    OP_CALL = 3'h1,
    OP_RET = 3'h2,
    OP_INTERRUPT_RETURN = 3'h3,
    OP_INT = 3'h4
  } ptc_op_e;

  // descriptor classes after fetch
  typedef enum logic [2:0] {
    DK_CODE = 3'h0,
    DK_CALL_GATE = 3'h1,
    DK_TRAP_GATE = 3'h2,
    DK_INT_GATE = 3'h3,
    DK_TASK_GATE = 3'h4,
    DK_TSS = 3'h5,
    DK_OTHER = 3'h6
  } ptc_kind_e;

  // table the descriptor was found in
  localparam logic [1:0] TB_GLOBAL = 2'h0;
  localparam logic [1:0] TB_LOCAL = 2'h1;
  localparam logic [1:0] TB_INTR = 2'h2;

  // sequencer states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_TSS_WT = 9'h002,
    ST_TSS_LD = 9'h004,
    ST_PUSH_SS = 9'h008,
    ST_PUSH_SP = 9'h010,
    ST_COPY_WT = 9'h020,
    ST_COPY_WR = 9'h040,
    ST_PUSH_CS = 9'h080,
    ST_PUSH_IP = 9'h100
  } ptc_state_e;
endpackage

// file: rtl/ptc_push_if.sv
// ptc_push_if: link between the transfer sequencer and the stack pusher.
// assumes: both ends share the core clock; ctl drives requests, stk answers from flops.
interface ptc_push_if;
  logic load;
  logic [31:0] load_sp;
  logic push;
  logic [31:0] push_data;
  logic push_wide;
  logic [31:0] sp;
  logic wr;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_wide;

  modport ctl (output load, load_sp, push, push_data, push_wide, input sp, wr, wr_addr, wr_data, wr_wide);
  modport stk (input load, load_sp, push, push_data, push_wide, output sp, wr, wr_addr, wr_data, wr_wide);
endinterface

// file: rtl/ptc_level_cmp.sv
// ptc_level_cmp: numeric privilege comparisons for one transfer.
// assumes: levels are two-bit, 0 most privileged; purely combinational.
module ptc_level_cmp (
  // levels in
  input wire logic [1:0] cur_level,
  input wire logic [1:0] requested_level,
  input wire logic [1:0] descriptor_level,
  input wire logic [1:0] target_level,
  // results
  output logic [1:0] effective_level,
  output logic gate_ok,
  output logic inward
);
  // larger number is the less trusted of the two
  assign effective_level = (requested_level > cur_level) ? requested_level : cur_level;
  assign gate_ok = (effective_level <= descriptor_level) && (cur_level <= descriptor_level);
  assign inward = (target_level <= cur_level);
endmodule

// file: rtl/ptc_stack_pusher.sv
// ptc_stack_pusher: keeps the new stack pointer and emits one write per push.
// assumes: load and push never in the same cycle; 16-bit pushes carry data in the low half.
module ptc_stack_pusher (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sequencer side
  ptc_push_if.stk pif
);
  typedef struct packed {
    logic [31:0] sp;
    logic wr;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_wide;
  } ptc_push_s;

  ptc_push_s s_r;
  ptc_push_s s_nxt;

  // predecrement, then write at the new top
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    if (pif.load)
      s_nxt.sp = pif.load_sp;
    else if (pif.push)
    begin
      s_nxt.sp = s_r.sp - (pif.push_wide ? ptc_pkg::SLOT32_BYTES : ptc_pkg::SLOT16_BYTES);
      s_nxt.wr = 1'b1;
      s_nxt.wr_addr = s_nxt.sp;
      s_nxt.wr_data = pif.push_wide ? pif.push_data : {16'h0000, pif.push_data[15:0]};
      s_nxt.wr_wide = pif.push_wide;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign pif.sp = s_r.sp;
  assign pif.wr = s_r.wr;
  assign pif.wr_addr = s_r.wr_addr;
  assign pif.wr_data = s_r.wr_data;
  assign pif.wr_wide = s_r.wr_wide;
endmodule

// file: rtl/ptc_checker.sv
// ptc_checker: validates far transfers and sequences the stack switch on inward calls.
// assumes: descriptor fetched by decode and presented with the request; requests only while busy is low.
// Contract
// - wrong descriptor type for the operation raises fault 13
// - same-level jump, call, return, nt-clear interrupt_return use code descriptor in global/local table
// - calls to same or inner level pass a call gate in global/local table
// - in-task interrupts vector via trap or interrupt gate in interrupt table
// - outward transfers only by return or nt-clear interrupt_return to a code descriptor
// - task switch by tss/task gate jump or call, nt-set interrupt_return, interrupt task gate
// - jump: non-conforming at equal level, conforming at equal or inner level
// - call: non-conforming at equal level, or via gate inward
// - in-task interrupts get the same checks as calls
// - gate needs requested and current level not above gate level
// - gate target code must be at or inside current level
// - returns go only to equal or outer level
// - task switch needs descriptor level not below current level numerically
// - level change loads stack for target level 0..2, pushes old stack
// - return outward restores the saved outer stack segment and pointer
// - level-crossing call copies exactly gate word count parameters
// - return with adjustment discards parameters, restoring caller stack pointer
// - gate access only when effective level not above gate level
// - gates never transfer outward
// - inward 32-bit gate: validate target, push ss, sp, params, return address
// - 16-bit gates do the same with 16-bit slots
// - interrupt gate clears interrupt enable, trap gate keeps it, no copying
// - requested level is selector bits 1:0
// - effective level is the numerically larger of current and requested
// - nested task flag is flags bit 14, choosing interrupt_return behaviour
module ptc_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // transfer request
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [15:0] req_sel,
  input wire logic [31:0] req_off,
  input wire logic [31:0] req_flags,
  input wire logic [15:0] req_imm,
  input wire logic [15:0] req_old_ss,
  input wire logic [31:0] req_old_sp,
  input wire logic [15:0] req_ret_cs,
  input wire logic [31:0] req_ret_ip,
  input wire logic [15:0] req_outer_ss,
  input wire logic [31:0] req_outer_sp,
  // fetched descriptor
  input wire logic [2:0] desc_kind,
  input wire logic [1:0] desc_table,
  input wire logic [1:0] desc_level,
  input wire logic desc_conforming,
  input wire logic desc_wide,
  input wire logic [4:0] gate_count,
  input wire logic [15:0] gate_sel,
  input wire logic [31:0] gate_off,
  input wire logic [1:0] gate_tgt_level,
  input wire logic gate_tgt_conforming,
  // task state segment stack entry
  output logic tss_rd_req,
  output logic [1:0] tss_rd_level,
  input wire logic [15:0] tss_ss,
  input wire logic [31:0] tss_sp,
  // parameter read from old stack
  output logic copy_rd_req,
  output logic [31:0] copy_rd_addr,
  input wire logic [31:0] copy_rd_data,
  // new stack writes
  output logic stack_wr,
  output logic [31:0] stack_wr_addr,
  output logic [31:0] stack_wr_data,
  output logic stack_wr_wide,
  // results
  output logic busy,
  output logic done,
  output logic fault,
  output logic [7:0] fault_vector,
  output logic task_switch,
  output logic [15:0] new_cs,
  output logic [31:0] new_ip,
  output logic [15:0] new_ss,
  output logic [31:0] new_sp,
  output logic [1:0] current_level,
  output logic if_flag
);
  typedef struct packed {
    ptc_pkg::ptc_state_e st;
    logic int_gate;
    logic wide;
    logic [4:0] wc;
    logic [4:0] cnt;
    logic [1:0] cur;
    logic [1:0] nlvl;
    logic ifl;
    logic [15:0] old_ss;
    logic [31:0] old_sp;
    logic [15:0] ret_cs;
    logic [31:0] ret_ip;
    logic [15:0] tcs;
    logic [31:0] tip;
    logic [15:0] nss;
    logic busy;
    logic done;
    logic fault;
    logic tsw;
    logic lastf;
    logic lasttsw;
    logic [7:0] fcnt;
    logic tss_req;
    logic [1:0] tss_lvl;
    logic cp_req;
    logic [31:0] cp_addr;
    logic [15:0] ncs;
    logic [31:0] nip;
    logic [7:0] fvec;
    logic [31:0] rdata;
  } ptc_core_s;

  ptc_core_s s_r;
  ptc_core_s s_nxt;
  ptc_push_if pif ();

  logic [1:0] rl;
  logic [1:0] eff;
  logic gate_ok;
  logic inward;
  logic in_gl;
  logic acc;
  logic ok;
  logic tsw;
  logic pushes;
  logic outer;
  logic [1:0] nlvl;
  logic p_load;
  logic [31:0] p_load_sp;
  logic p_push;
  logic [31:0] p_data;
  logic [4:0] idx;
  logic [31:0] cp_off;

  assign rl = req_sel[ptc_pkg::RL_MSB:ptc_pkg::RL_LSB];
  assign in_gl = (desc_table == ptc_pkg::TB_GLOBAL) || (desc_table == ptc_pkg::TB_LOCAL);
  assign acc = req_valid && (s_r.st == ptc_pkg::ST_IDLE);

  ptc_level_cmp u_cmp (
    .cur_level(s_r.cur),
    .requested_level(rl),
    .descriptor_level(desc_level),
    .target_level(gate_tgt_level),
    .effective_level(eff),
    .gate_ok(gate_ok),
    .inward(inward)
  );

  // type and level decision for the presented transfer; anything unmatched stays refused
  always_comb
  begin
    ok = 1'b0;
    tsw = 1'b0;
    pushes = 1'b0;
    outer = 1'b0;
    nlvl = s_r.cur;
    unique case (req_op)
      ptc_pkg::OP_JUMP, ptc_pkg::OP_CALL:
      begin
        if (desc_kind == ptc_pkg::DK_CODE && in_gl)
        begin
          // conforming code runs at the caller's level
          ok = desc_conforming ? (desc_level <= s_r.cur) : (desc_level == s_r.cur);
          pushes = (req_op == ptc_pkg::OP_CALL);
        end
        else if ((desc_kind == ptc_pkg::DK_TSS && desc_table == ptc_pkg::TB_GLOBAL) ||
                 (desc_kind == ptc_pkg::DK_TASK_GATE && in_gl))
        begin
          tsw = 1'b1;
          ok = (desc_level >= s_r.cur);
        end
        else if (req_op == ptc_pkg::OP_CALL && desc_kind == ptc_pkg::DK_CALL_GATE && in_gl)
        begin
          ok = gate_ok && inward;
          nlvl = gate_tgt_conforming ? s_r.cur : gate_tgt_level;
          pushes = 1'b1;
        end
      end
      ptc_pkg::OP_INT:
      begin
        if (desc_table == ptc_pkg::TB_INTR)
        begin
          if (desc_kind == ptc_pkg::DK_TRAP_GATE || desc_kind == ptc_pkg::DK_INT_GATE)
          begin
            ok = gate_ok && inward;
            nlvl = gate_tgt_conforming ? s_r.cur : gate_tgt_level;
            pushes = 1'b1;
          end
          else if (desc_kind == ptc_pkg::DK_TASK_GATE)
          begin
            tsw = 1'b1;
            ok = (desc_level >= s_r.cur);
          end
        end
      end
      ptc_pkg::OP_RET, ptc_pkg::OP_INTERRUPT_RETURN:
      begin
        if (req_op == ptc_pkg::OP_INTERRUPT_RETURN && req_flags[ptc_pkg::NT_BIT])
        begin
          tsw = 1'b1;
          ok = 1'b1;
        end
        else if (desc_kind == ptc_pkg::DK_CODE && in_gl)
        begin
          ok = (rl >= s_r.cur) && (desc_conforming ? (desc_level <= rl) : (desc_level == rl));
          nlvl = rl;
          outer = (rl != s_r.cur);
        end
      end
      default:
      begin
        ok = 1'b0;
      end
    endcase
  end

  // next state: register port first, so transfer results override a racing write
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.fault = 1'b0;
    s_nxt.tsw = 1'b0;
    s_nxt.tss_req = 1'b0;
    s_nxt.cp_req = 1'b0;
    s_nxt.rdata = 32'h0000_0000;
    p_load = 1'b0;
    p_load_sp = 32'h0000_0000;
    p_push = 1'b0;
    p_data = 32'h0000_0000;
    idx = 5'h00;
    cp_off = 32'h0000_0000;
    if (reg_wr && reg_addr == ptc_pkg::REG_CTRL)
    begin
      s_nxt.ifl = reg_wdata[ptc_pkg::CTRL_IF_BIT];
      s_nxt.cur = reg_wdata[ptc_pkg::CTRL_LVL_LSB +: 2];
    end
    if (reg_wr && reg_addr == ptc_pkg::REG_STATUS)
    begin
      // write one to clear sticky bits
      if (reg_wdata[ptc_pkg::STAT_FAULT_BIT])
        s_nxt.lastf = 1'b0;
      if (reg_wdata[ptc_pkg::STAT_TSW_BIT])
        s_nxt.lasttsw = 1'b0;
    end
    if (reg_rd)
    begin
      if (reg_addr == ptc_pkg::REG_CTRL)
        s_nxt.rdata = {29'h0, s_r.cur, s_r.ifl};
      else if (reg_addr == ptc_pkg::REG_STATUS)
        s_nxt.rdata = {16'h0000, s_r.fcnt, 5'h00, s_r.lasttsw, s_r.lastf, s_r.busy};
    end
    unique case (s_r.st)
      ptc_pkg::ST_IDLE:
      begin
        if (acc && !ok)
        begin
          s_nxt.done = 1'b1;
          s_nxt.fault = 1'b1;
          s_nxt.fvec = ptc_pkg::GP_FAULT_VEC;
          s_nxt.lastf = 1'b1;
          s_nxt.fcnt = s_r.fcnt + 8'h01;
        end
        else if (acc && tsw)
        begin
          // save and restore of task state happen outside
          s_nxt.done = 1'b1;
          s_nxt.tsw = 1'b1;
          s_nxt.lasttsw = 1'b1;
        end
        else if (acc && pushes)
        begin
          s_nxt.int_gate = (desc_kind == ptc_pkg::DK_INT_GATE);
          s_nxt.wide = desc_wide;
          // only level-crossing call gates carry parameters; same-level gates reuse the caller stack
          s_nxt.wc = (desc_kind == ptc_pkg::DK_CALL_GATE && nlvl != s_r.cur) ? gate_count : 5'h00;
          s_nxt.cnt = 5'h00;
          s_nxt.nlvl = nlvl;
          s_nxt.old_ss = req_old_ss;
          s_nxt.old_sp = req_old_sp;
          s_nxt.ret_cs = req_ret_cs;
          s_nxt.ret_ip = req_ret_ip;
          s_nxt.tcs = (desc_kind == ptc_pkg::DK_CODE) ? req_sel : {gate_sel[15:2], nlvl};
          s_nxt.tip = (desc_kind == ptc_pkg::DK_CODE) ? req_off : gate_off;
          if (nlvl != s_r.cur)
          begin
            s_nxt.tss_req = 1'b1;
            s_nxt.tss_lvl = nlvl;
            s_nxt.st = ptc_pkg::ST_TSS_WT;
          end
          else
          begin
            s_nxt.nss = req_old_ss;
            p_load = 1'b1;
            p_load_sp = req_old_sp;
            s_nxt.st = ptc_pkg::ST_PUSH_CS;
          end
        end
        else if (acc)
        begin
          // jump or return completes at once
          s_nxt.done = 1'b1;
          s_nxt.cur = nlvl;
          s_nxt.ncs = req_sel;
          s_nxt.nip = req_off;
          p_load = 1'b1;
          if (req_op == ptc_pkg::OP_JUMP)
          begin
            s_nxt.nss = req_old_ss;
            p_load_sp = req_old_sp;
          end
          else if (outer)
          begin
            s_nxt.nss = req_outer_ss;
            p_load_sp = req_outer_sp + {16'h0000, req_imm};
          end
          else
          begin
            s_nxt.nss = req_old_ss;
            p_load_sp = req_old_sp + {16'h0000, req_imm};
          end
        end
      end
      ptc_pkg::ST_TSS_WT:
        s_nxt.st = ptc_pkg::ST_TSS_LD;
      ptc_pkg::ST_TSS_LD:
      begin
        s_nxt.nss = tss_ss;
        p_load = 1'b1;
        p_load_sp = tss_sp;
        s_nxt.st = ptc_pkg::ST_PUSH_SS;
      end
      ptc_pkg::ST_PUSH_SS:
      begin
        p_push = 1'b1;
        p_data = {16'h0000, s_r.old_ss};
        s_nxt.st = ptc_pkg::ST_PUSH_SP;
      end
      ptc_pkg::ST_PUSH_SP, ptc_pkg::ST_COPY_WR:
      begin
        p_push = 1'b1;
        p_data = (s_r.st == ptc_pkg::ST_PUSH_SP) ? s_r.old_sp : copy_rd_data;
        if (s_r.st == ptc_pkg::ST_COPY_WR)
          s_nxt.cnt = s_r.cnt + 5'h01;
        if (s_nxt.cnt == s_r.wc)
          s_nxt.st = ptc_pkg::ST_PUSH_CS;
        else
        begin
          // deepest parameter first keeps the caller's order
          idx = s_r.wc - 5'h01 - s_nxt.cnt;
          cp_off = s_r.wide ? {25'h0, idx, 2'h0} : {26'h0, idx, 1'h0};
          s_nxt.cp_req = 1'b1;
          s_nxt.cp_addr = s_r.old_sp + cp_off;
          s_nxt.st = ptc_pkg::ST_COPY_WT;
        end
      end
      ptc_pkg::ST_COPY_WT:
        s_nxt.st = ptc_pkg::ST_COPY_WR;
      ptc_pkg::ST_PUSH_CS:
      begin
        p_push = 1'b1;
        p_data = {16'h0000, s_r.ret_cs};
        s_nxt.st = ptc_pkg::ST_PUSH_IP;
      end
      ptc_pkg::ST_PUSH_IP:
      begin
        p_push = 1'b1;
        p_data = s_r.ret_ip;
        s_nxt.done = 1'b1;
        s_nxt.cur = s_r.nlvl;
        s_nxt.ncs = s_r.tcs;
        s_nxt.nip = s_r.tip;
        if (s_r.int_gate)
          s_nxt.ifl = 1'b0;
        s_nxt.st = ptc_pkg::ST_IDLE;
      end
    endcase
    s_nxt.busy = (s_nxt.st != ptc_pkg::ST_IDLE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.st <= ptc_pkg::ST_IDLE;
      s_r.cur <= ptc_pkg::CUR_LEVEL_RST;
      s_r.ifl <= ptc_pkg::IF_RST;
    end
    else
      s_r <= s_nxt;
  end

  // pusher owns the new stack pointer and the write strobe
  assign pif.load = p_load;
  assign pif.load_sp = p_load_sp;
  assign pif.push = p_push;
  assign pif.push_data = p_data;
  assign pif.push_wide = s_r.wide;

  ptc_stack_pusher u_push (
    .clk(clk),
    .rst(rst),
    .pif(pif)
  );

  assign reg_rdata = s_r.rdata;
  assign tss_rd_req = s_r.tss_req;
  assign tss_rd_level = s_r.tss_lvl;
  assign copy_rd_req = s_r.cp_req;
  assign copy_rd_addr = s_r.cp_addr;
  assign stack_wr = pif.wr;
  assign stack_wr_addr = pif.wr_addr;
  assign stack_wr_data = pif.wr_data;
  assign stack_wr_wide = pif.wr_wide;
  assign busy = s_r.busy;
  assign done = s_r.done;
  assign fault = s_r.fault;
  assign fault_vector = s_r.fvec;
  assign task_switch = s_r.tsw;
  assign new_cs = s_r.ncs;
  assign new_ip = s_r.nip;
  assign new_ss = s_r.nss;
  assign new_sp = pif.sp;
  assign current_level = s_r.cur;
  assign if_flag = s_r.ifl;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence gate_entry_int;
    acc && ok && pushes && desc_kind == ptc_pkg::DK_INT_GATE;
  endsequence
  sequence gate_entry_trap;
    acc && ok && pushes && desc_kind == ptc_pkg::DK_TRAP_GATE && !(reg_wr && reg_addr == ptc_pkg::REG_CTRL);
  endsequence

  AST_JUMP_GATE_FAULT: assert property (
    acc && req_op == ptc_pkg::OP_JUMP && desc_kind == ptc_pkg::DK_CALL_GATE
    |=> fault && fault_vector == 8'h0d)
    else $error("jump through call gate not refused");
  AST_JUMP_LEVEL: assert property (
    acc && req_op == ptc_pkg::OP_JUMP && desc_kind == ptc_pkg::DK_CODE && !desc_conforming
    && desc_level != current_level |=> fault)
    else $error("jump to other-level code allowed");
  AST_GATE_EFF: assert property (
    acc && req_op == ptc_pkg::OP_CALL && desc_kind == ptc_pkg::DK_CALL_GATE && eff > desc_level |=> fault)
    else $error("gate used above effective level");
  // task gates name no target code, so only trap and interrupt gates are held to the level
  AST_GATE_OUTWARD: assert property (
    acc && req_op == ptc_pkg::OP_INT && gate_tgt_level > current_level
    && (desc_kind == ptc_pkg::DK_TRAP_GATE || desc_kind == ptc_pkg::DK_INT_GATE) |=> fault)
    else $error("gate transferred outward");
  // a racing level write lands on a refused transfer, so it is left out here
  AST_RET_INWARD: assert property (
    acc && req_op == ptc_pkg::OP_RET && rl < current_level && !reg_wr
    |=> fault && current_level == $past(current_level))
    else $error("return went inward");
  AST_NT_SWITCH: assert property (
    acc && req_op == ptc_pkg::OP_INTERRUPT_RETURN && req_flags[ptc_pkg::NT_BIT] |=> task_switch && done && !fault)
    else $error("nested interrupt_return did not switch task");
  // interrupt gates copy nothing, so done follows entry within seven cycles
  AST_INT_IF: assert property (
    gate_entry_int |-> ##[1:8] (done && !if_flag))
    else $error("interrupt gate left interrupts enabled");
  AST_TRAP_IF: assert property (
    gate_entry_trap |=> $stable(if_flag) [*2])
    else $error("trap gate changed interrupt enable");
  AST_TSS_LVL: assert property (
    tss_rd_req |-> tss_rd_level < current_level ##2 new_ss == $past(tss_ss))
    else $error("stack entry level or load wrong");
  AST_PUSH_ORDER: assert property (
    s_r.st == ptc_pkg::ST_PUSH_SS |=> stack_wr && stack_wr_data == {16'h0000, $past(s_r.old_ss)}
    ##1 stack_wr && stack_wr_data == (stack_wr_wide ? $past(s_r.old_sp, 2) : {16'h0000, $past(s_r.old_sp[15:0], 2)}))
    else $error("old stack not pushed in order");
  AST_COPY_COUNT: assert property (
    s_r.st == ptc_pkg::ST_PUSH_CS |-> s_r.cnt == s_r.wc)
    else $error("parameter count mismatch");
  AST_RET_SP: assert property (
    acc && ok && !tsw && req_op == ptc_pkg::OP_RET && outer
    |=> new_sp == $past(req_outer_sp) + {16'h0000, $past(req_imm)})
    else $error("outer stack not restored");
endmodule

// file: bench/privilege_transfer_checker_tb.sv
// privilege_transfer_checker_tb: self-checking bench for the transfer checker.
// assumes: the bench answers stack-entry and old-stack reads itself.
module privilege_transfer_checker_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus, idle at time zero
  logic clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, req_valid = 1'h0;
  logic desc_conforming = 1'h0, desc_wide = 1'h1, gate_tgt_conforming = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = '0, req_off = '0, req_flags = '0, req_old_sp = '0, req_ret_ip = '0;
  logic [31:0] req_outer_sp = '0, gate_off = '0, tss_sp = '0, copy_rd_data = '0;
  logic [15:0] req_sel = '0, req_imm = '0, req_old_ss = '0, req_ret_cs = '0, req_outer_ss = '0;
  logic [15:0] gate_sel = '0, tss_ss = '0;
  logic [2:0] req_op = '0, desc_kind = '0;
  logic [1:0] desc_table = '0, desc_level = '0, gate_tgt_level = '0;
  logic [4:0] gate_count = '0;
  // observed
  logic [31:0] reg_rdata, copy_rd_addr, stack_wr_addr, stack_wr_data, new_ip, new_sp;
  logic tss_rd_req, copy_rd_req, stack_wr, stack_wr_wide, busy, done, fault, task_switch, if_flag, ts;
  logic [1:0] tss_rd_level, current_level, lvl_seen;
  logic [7:0] fault_vector;
  logic [15:0] new_cs, new_ss;
  logic [31:0] wq[$], aq[$];
  int n_fail = 0, comparisons = 0;

  ptc_checker u_ptc_checker (.*);

  always #25 clk = ~clk;
  // old-stack data follows the address, so a wrong read address shows
  always @(posedge clk) copy_rd_data <= ~copy_rd_addr;
  // log of pushes and of the stack entry asked for
  always @(posedge clk)
  begin
    if (stack_wr === 1'h1)
    begin
      wq.push_back(stack_wr_data);
      aq.push_back(stack_wr_addr);
    end
    if (tss_rd_req === 1'h1)
      lvl_seen <= tss_rd_level;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // register port: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  // one transfer; waits for done under a bound, then judges the fault pulse
  task automatic xfer(input logic [2:0] op, input logic [2:0] k, input logic [1:0] tb, input logic [15:0] sel,
                      input logic [1:0] lvl, input logic flt);
    wq.delete();
    aq.delete();
    @(posedge clk);
    req_op <= op;
    desc_kind <= k;
    desc_table <= tb;
    req_sel <= sel;
    desc_level <= lvl;
    req_valid <= 1'h1;
    @(posedge clk);
    req_valid <= 1'h0;
    for (int i = 0; i < 64 && done !== 1'h1; i++)
      @(negedge clk);
    if (done !== 1'h1)
    begin
      n_fail++;
      end_of_test();
    end
    ts = task_switch;
    chk(32'(fault), 32'(flt));
    // the push that stands with done is logged only at the following edge
    @(negedge clk);
  endtask

  task automatic t_jump();
    wr(ptc_pkg::REG_CTRL, 32'h7);
    rd(ptc_pkg::REG_CTRL, 32'h7);
    rd(4'h8, 32'h0);
    xfer(ptc_pkg::OP_JUMP, ptc_pkg::DK_CODE, ptc_pkg::TB_GLOBAL, 16'h001b, 2'h3, 1'h0);
    xfer(ptc_pkg::OP_JUMP, ptc_pkg::DK_CODE, ptc_pkg::TB_GLOBAL, 16'h0013, 2'h2, 1'h1);
    chk(32'(fault_vector), 32'h0d);
    @(posedge clk);
    desc_conforming <= 1'h1;
    xfer(ptc_pkg::OP_JUMP, ptc_pkg::DK_CODE, ptc_pkg::TB_GLOBAL, 16'h0003, 2'h0, 1'h0);
    @(posedge clk);
    desc_conforming <= 1'h0;
    chk(32'(current_level), 32'h3);
    xfer(ptc_pkg::OP_JUMP, ptc_pkg::DK_CALL_GATE, ptc_pkg::TB_GLOBAL, 16'h001b, 2'h3, 1'h1);
    xfer(ptc_pkg::OP_JUMP, ptc_pkg::DK_TSS, ptc_pkg::TB_GLOBAL, 16'h001b, 2'h2, 1'h1);
    xfer(ptc_pkg::OP_JUMP, ptc_pkg::DK_TSS, ptc_pkg::TB_GLOBAL, 16'h001b, 2'h3, 1'h0);
    chk(32'(ts), 32'h1);
    rd(ptc_pkg::REG_STATUS, 32'h0000_0306);
  endtask

  // inward call, wide then narrow gate; params read deepest first
  task automatic t_call(input logic wide, input logic [31:0] ex_sp, input logic [31:0] ex_p);
    wr(ptc_pkg::REG_CTRL, 32'h7);
    {req_old_ss, req_old_sp, req_ret_cs, req_ret_ip} <= {16'h002b, 32'h1000, 16'h0033, 32'h2000};
    {tss_ss, tss_sp, gate_count, gate_tgt_level, desc_wide} <= {16'h0010, 32'h8000, 5'h2, 2'h0, wide};
    {gate_sel, gate_off} <= {16'h0049, 32'h3000};
    xfer(ptc_pkg::OP_CALL, ptc_pkg::DK_CALL_GATE, ptc_pkg::TB_GLOBAL, 16'h001b, 2'h2, 1'h1);
    xfer(ptc_pkg::OP_CALL, ptc_pkg::DK_CALL_GATE, ptc_pkg::TB_GLOBAL, 16'h001b, 2'h3, 1'h0);
    chk(32'(lvl_seen), 32'h0);
    chk(32'(wq.size()), 32'h6);
    chk(wq[0], 32'h002b);
    chk(wq[2], ex_p);
    chk(wq[5], 32'h2000);
    chk(aq[0], wide ? 32'h7ffc : 32'h7ffe);
    chk(new_sp, ex_sp);
    chk(32'(current_level), 32'h0);
    chk(32'(new_cs), 32'h0048);
    chk(new_ip, 32'h3000);
  endtask

  // outward return with adjustment, refused inward return, nested interrupt_return
  task automatic t_ret();
    @(posedge clk);
    {req_outer_ss, req_outer_sp, req_imm} <= {16'h002b, 32'h1000, 16'h0004};
    xfer(ptc_pkg::OP_RET, ptc_pkg::DK_CODE, ptc_pkg::TB_GLOBAL, 16'h001b, 2'h3, 1'h0);
    chk(32'(new_ss), 32'h002b);
    chk(new_sp, 32'h1004);
    chk(32'(current_level), 32'h3);
    xfer(ptc_pkg::OP_RET, ptc_pkg::DK_CODE, ptc_pkg::TB_GLOBAL, 16'h0018, 2'h0, 1'h1);
    @(posedge clk);
    req_flags <= 32'h4000;
    xfer(ptc_pkg::OP_INTERRUPT_RETURN, ptc_pkg::DK_TSS, ptc_pkg::TB_GLOBAL, 16'h001b, 2'h3, 1'h0);
    chk(32'(ts), 32'h1);
    @(posedge clk);
    req_flags <= 32'h0;
  endtask

  // same-level interrupts: trap keeps enable, interrupt gate clears it
  task automatic t_int(input logic [2:0] k, input logic ex_if);
    wr(ptc_pkg::REG_CTRL, 32'h7);
    gate_tgt_level <= 2'h3;
    xfer(ptc_pkg::OP_INT, k, ptc_pkg::TB_INTR, 16'h001b, 2'h3, 1'h0);
    chk(32'(if_flag), 32'(ex_if));
    chk(32'(wq.size()), 32'h2);
    xfer(ptc_pkg::OP_INT, ptc_pkg::DK_CALL_GATE, ptc_pkg::TB_INTR, 16'h001b, 2'h3, 1'h1);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rd(ptc_pkg::REG_CTRL, 32'h0);
    t_jump();
    t_call(1'h1, 32'h7fe8, 32'hffffeffb);
    t_call(1'h0, 32'h7ff4, 32'h0000effd);
    t_ret();
    t_int(ptc_pkg::DK_TRAP_GATE, 1'h1);
    t_int(ptc_pkg::DK_INT_GATE, 1'h0);
    end_of_test();
  end
endmodule
